// file: core/dma_channel_status_select.sv
// Channel status, active channel snapshot and channel selection registers
`timescale 1ns/1ps

module dma_channel_status_select #(
  parameter int NCH = dma_status_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_SYS_RST,
  // APB slave
  input  wire logic                    I_PSEL,
  input  wire logic                    I_PENABLE,
  input  wire logic                    I_PWRITE,
  input  wire logic [11:0]             I_PADDR,
  input  wire logic [31:0]             I_PWDATA,
  output logic      [31:0]             O_PRDATA,
  output logic                         O_PREADY,
  output logic                         O_PSLVERR,
  // Protection
  input  wire logic                    I_WR_PROTECT,
  input  wire logic                    I_DMAC_EN,
  // Per-channel engine events
  input  wire logic [NCH-1:0]          I_PEND_SET,
  input  wire logic [NCH-1:0]          I_TRIG_START,
  input  wire logic [NCH-1:0]          I_BUS_ERR,
  input  wire logic [NCH-1:0]          I_CH_ACTIVE,
  input  wire logic [NCH-1:0]          I_ABORT_DONE,
  input  wire logic [3:0]              I_LVL_REQ,
  // Arbiter and active channel
  input  wire logic                    I_GRANT,
  input  wire logic [3:0]              I_GRANT_CH,
  input  wire logic                    I_CNT_LOAD,
  input  wire logic [15:0]             I_CNT_VALUE,
  input  wire logic                    I_BEAT_DONE,
  // Channel controls to the engine
  output logic      [NCH-1:0]          O_CH_ENABLE,
  output logic      [NCH-1:0]          O_ABORT_REQ,
  output logic      [2*NCH-1:0]        O_TRIG_ACT,
  output logic      [31:0]             O_DESC_BASE,
  // Write-back of the active count
  output logic                         O_WB_VALID,
  output logic      [31:0]             O_WB_ADDR,
  output logic      [15:0]             O_WB_COUNT,
  // Interrupt
  output logic                         O_IRQ
);

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  logic                     pready_r;
  logic [31:0]              prdata_r;
  logic                     pslverr_r;
  logic [31:0]              desc_base_r;
  logic [31:0]              wrb_base_r;
  logic [3:0]               chsel_r;
  logic [NCH-1:0]           en_r;
  logic [NCH-1:0]           stop_r;
  logic [NCH-1:0]           channel_soft_reset_r;
  logic [NCH-1:0]           pend_r;
  logic [1:0]               trig_r [NCH];
  logic [15:0]              cnt_r;
  logic                     busy_r;
  logic [4:0]               id_r;
  logic [3:0]               lvl_r;
  logic                     wb_valid_r;
  logic [31:0]              wb_addr_r;
  logic [15:0]              wb_cnt_r;
  logic [dma_status_pkg::NUM_EV-1:0] stat_r;
  logic [dma_status_pkg::NUM_EV-1:0] mask_r;
  logic [dma_status_pkg::NUM_EV-1:0] stat_nxt;
  logic [dma_status_pkg::NUM_EV-1:0] ev;
  logic                     irq_r;
  logic                     setup;
  logic                     wr;
  logic                     hit;
  logic                     wr_base_ok;
  logic                     wr_ctrl;
  logic                     wr_trig;
  logic [31:0]              rd_mux;
  logic [1:0]               trig_sel;

  assign setup = I_PSEL & ~I_PENABLE;
  // Access phase is always a single cycle: pready follows setup
  assign wr    = I_PSEL & I_PENABLE & pready_r & I_PWRITE;

  // Base registers are frozen while protected or while the controller runs
  assign wr_base_ok = wr & ~I_WR_PROTECT & ~I_DMAC_EN;
  assign wr_ctrl    = wr & ~I_WR_PROTECT &
                      (I_PADDR == dma_status_pkg::ADDR_CTRL);
  assign wr_trig    = wr_base_ok & (I_PADDR == dma_status_pkg::ADDR_TRIG);
  assign trig_sel   = (32'(chsel_r) < NCH) ? trig_r[chsel_r] : 2'h0;

  always_comb begin
    hit    = 1'b1;
    rd_mux = dma_status_pkg::RST_WORD;
    unique case (I_PADDR)
      dma_status_pkg::ADDR_PEND:     rd_mux = 32'(pend_r);
      dma_status_pkg::ADDR_ACTIVE:   rd_mux = {cnt_r, busy_r, 2'h0, id_r,
                                               4'h0, lvl_r};
      dma_status_pkg::ADDR_DESC:     rd_mux = desc_base_r;
      dma_status_pkg::ADDR_WRB:      rd_mux = wrb_base_r;
      dma_status_pkg::ADDR_CHSEL:    rd_mux = 32'(chsel_r);
      dma_status_pkg::ADDR_CTRL: begin
        if (32'(chsel_r) < NCH) begin
          rd_mux = {30'h0, en_r[chsel_r], channel_soft_reset_r[chsel_r]};
        end
      end
      dma_status_pkg::ADDR_TRIG:     rd_mux = 32'(trig_sel);
      dma_status_pkg::ADDR_IRQ_STAT: rd_mux = 32'(stat_r);
      dma_status_pkg::ADDR_IRQ_MASK: rd_mux = 32'(mask_r);
      default:                       hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      pready_r  <= 1'b0;
      prdata_r  <= dma_status_pkg::RST_WORD;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= hit ? rd_mux : dma_status_pkg::RST_WORD;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      desc_base_r <= dma_status_pkg::RST_WORD;
      wrb_base_r  <= dma_status_pkg::RST_WORD;
      chsel_r     <= dma_status_pkg::RST_CHSEL;
    end else begin
      if (wr_base_ok && I_PADDR == dma_status_pkg::ADDR_DESC) begin
        desc_base_r <= I_PWDATA;
      end
      if (wr_base_ok && I_PADDR == dma_status_pkg::ADDR_WRB) begin
        wrb_base_r <= I_PWDATA;
      end
      if (wr && I_PADDR == dma_status_pkg::ADDR_CHSEL) begin
        chsel_r <= I_PWDATA[3:0];
      end
    end
  end

  // Per-channel control; only the selected channel sees a write
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic sel;
    logic wen;
    assign sel = (32'(chsel_r) == g);
    assign wen = wr_ctrl & sel;

    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
        en_r[g]   <= 1'b0;
        stop_r[g] <= 1'b0;
      end else if (wen && I_PWDATA[dma_status_pkg::CTRL_EN_BIT]) begin
        en_r[g]   <= 1'b1;
        stop_r[g] <= 1'b0;
      end else if (wen && !I_CH_ACTIVE[g]) begin
        en_r[g]   <= 1'b0;
        stop_r[g] <= 1'b0;
      end else if (wen && en_r[g]) begin
        stop_r[g] <= 1'b1;
      end else if (stop_r[g] && I_ABORT_DONE[g]) begin
        en_r[g]   <= 1'b0;
        stop_r[g] <= 1'b0;
      end
    end

    // Self-clearing one cycle after it is accepted
    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
        channel_soft_reset_r[g] <= 1'b0;
      end else if (channel_soft_reset_r[g]) begin
        channel_soft_reset_r[g] <= 1'b0;
      end else if (wen && I_PWDATA[dma_status_pkg::CTRL_RST_BIT] &&
                   !I_PWDATA[dma_status_pkg::CTRL_EN_BIT] && !en_r[g]) begin
        channel_soft_reset_r[g] <= 1'b1;
      end
    end

    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || channel_soft_reset_r[g]) begin
        pend_r[g] <= 1'b0;
      end else if (I_PEND_SET[g] && en_r[g]) begin
        pend_r[g] <= 1'b1;
      end else if (I_TRIG_START[g] || I_BUS_ERR[g] || !en_r[g]) begin
        pend_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST || channel_soft_reset_r[g]) begin
        trig_r[g] <= dma_status_pkg::TRIG_BLOCK;
      end else if (wr_trig && sel &&
                   I_PWDATA[1:0] != dma_status_pkg::TRIG_RSVD) begin
        trig_r[g] <= I_PWDATA[1:0];
      end
    end
    assign O_TRIG_ACT[2*g +: 2] = trig_r[g];

    AST_PEND_SET: assert property (I_PEND_SET[g] && en_r[g]
      |=> pend_r[g]) else $error("pending not set");
    AST_PEND_CLR: assert property ((I_TRIG_START[g] || I_BUS_ERR[g]) &&
      !I_PEND_SET[g] |=> !pend_r[g]) else $error("pending kept");
    AST_EN_HOLD: assert property (stop_r[g] && !I_ABORT_DONE[g] && !wen
      |=> en_r[g]) else $error("enable dropped early");
    AST_CHANNEL_SOFT_RESET_IGN: assert property (en_r[g] |=> !$rose(channel_soft_reset_r[g]))
      else $error("soft reset taken while enabled");
    AST_CHANNEL_SOFT_RESET_SELF: assert property (channel_soft_reset_r[g] |=> !channel_soft_reset_r[g] &&
      !pend_r[g] && trig_r[g] == dma_status_pkg::TRIG_BLOCK)
      else $error("soft reset incomplete");
    AST_OTHER_CH: assert property (wr_ctrl && !sel && !stop_r[g] &&
      !channel_soft_reset_r[g] |=> $stable(en_r[g]))
      else $error("unselected channel changed");
    AST_TRIG_RSVD: assert property (
      trig_r[g] != dma_status_pkg::TRIG_RSVD)
      else $error("reserved trigger action stored");
  end

  // Active channel snapshot
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      id_r   <= 5'h00;
    end else begin
      if (I_GRANT) begin
        id_r   <= {1'b0, I_GRANT_CH};
        busy_r <= 1'b0;
      end
      if (I_CNT_LOAD) begin
        cnt_r  <= I_CNT_VALUE;
        busy_r <= 1'b1;
      end else if (I_BEAT_DONE && busy_r) begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  // A stale count is written back only if the snapshot was live
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      wb_valid_r <= 1'b0;
      wb_addr_r  <= dma_status_pkg::RST_WORD;
      wb_cnt_r   <= 16'h0000;
    end else begin
      wb_valid_r <= I_GRANT & busy_r;
      if (I_GRANT && busy_r) begin
        wb_cnt_r  <= cnt_r;
        wb_addr_r <= wrb_base_r + dma_status_pkg::CNT_OFS +
                     32'(dma_status_pkg::DESC_BYTES * 32'(id_r));
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      lvl_r <= 4'h0;
    end else begin
      lvl_r <= I_LVL_REQ;
    end
  end

  // Interrupt status: set wins over a same-cycle write-one clear
  assign ev[dma_status_pkg::EV_BUS_ERR]   = |I_BUS_ERR;
  assign ev[dma_status_pkg::EV_ABORTED]   = |(stop_r & I_ABORT_DONE);
  assign ev[dma_status_pkg::EV_WRITEBACK] = wb_valid_r;

  always_comb begin
    stat_nxt = stat_r;
    if (wr && I_PADDR == dma_status_pkg::ADDR_IRQ_STAT) begin
      stat_nxt = stat_r & ~I_PWDATA[dma_status_pkg::NUM_EV-1:0];
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_r & mask_r);
      if (wr && I_PADDR == dma_status_pkg::ADDR_IRQ_MASK) begin
        mask_r <= I_PWDATA[dma_status_pkg::NUM_EV-1:0];
      end
    end
  end

  assign O_PRDATA    = prdata_r;
  assign O_PREADY    = pready_r;
  assign O_PSLVERR   = pslverr_r;
  assign O_CH_ENABLE = en_r;
  assign O_ABORT_REQ = stop_r;
  assign O_DESC_BASE = desc_base_r;
  assign O_WB_VALID  = wb_valid_r;
  assign O_WB_ADDR   = wb_addr_r;
  assign O_WB_COUNT  = wb_cnt_r;
  assign O_IRQ       = irq_r;

  AST_CNT_FIELD: assert property (setup && !I_PWRITE &&
    I_PADDR == dma_status_pkg::ADDR_ACTIVE
    |=> O_PRDATA[31:16] == $past(cnt_r) && O_PRDATA[15] == $past(busy_r))
    else $error("active count field wrong");
  AST_WB_GRANT: assert property (I_GRANT && busy_r
    |=> O_WB_VALID && O_WB_COUNT == $past(cnt_r))
    else $error("write-back missing");
  AST_BUSY_SET: assert property (I_CNT_LOAD |=> busy_r &&
    cnt_r == $past(I_CNT_VALUE)) else $error("busy not set");
  AST_BUSY_CLR: assert property (I_GRANT && !I_CNT_LOAD |=> !busy_r)
    else $error("busy not cleared on write-back");
  AST_ID_UPD: assert property (I_GRANT |=>
    id_r == {1'b0, $past(I_GRANT_CH)})
    else $error("active index stale");
  AST_LVL: assert property (1'b1 |=> lvl_r == $past(I_LVL_REQ))
    else $error("level flag stale");
  AST_BASE_PROT: assert property (wr && (I_WR_PROTECT || I_DMAC_EN)
    |=> $stable(desc_base_r) && $stable(wrb_base_r))
    else $error("protected base written");

  COV_WRITEBACK: cover property (I_CNT_LOAD ##[1:20] I_GRANT && busy_r);
  COV_ABORT: cover property (|stop_r ##[1:20] |(stop_r & I_ABORT_DONE));
  COV_CHANNEL_SOFT_RESET: cover property (|channel_soft_reset_r);
  COV_IRQ: cover property (O_IRQ);

endmodule

// file: common/dma_status_pkg.sv
// Constants shared by the channel status and selection block
package dma_status_pkg;
  localparam int          NUM_CH       = 12;
  localparam int          ADDR_W       = 12;
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_PEND     = 8'h2c;
  localparam logic [7:0]  IDX_ACTIVE   = 8'h30;
  localparam logic [7:0]  IDX_DESC     = 8'h34;
  localparam logic [7:0]  IDX_WRB      = 8'h38;
  localparam logic [7:0]  IDX_CHSEL    = 8'h3f;
  localparam logic [7:0]  IDX_CTRL     = 8'h40;
  localparam logic [7:0]  IDX_TRIG     = 8'h50;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h54;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'h58;
  localparam logic [11:0] ADDR_PEND     = {2'h0, IDX_PEND, 2'h0};
  localparam logic [11:0] ADDR_ACTIVE   = {2'h0, IDX_ACTIVE, 2'h0};
  localparam logic [11:0] ADDR_DESC     = {2'h0, IDX_DESC, 2'h0};
  localparam logic [11:0] ADDR_WRB      = {2'h0, IDX_WRB, 2'h0};
  localparam logic [11:0] ADDR_CHSEL    = {2'h0, IDX_CHSEL, 2'h0};
  localparam logic [11:0] ADDR_CTRL     = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_TRIG     = {2'h0, IDX_TRIG, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [3:0]  RST_CHSEL    = 4'h0;
  // Field positions
  localparam int          ACT_CNT_LSB  = 16;
  localparam int          ACT_BUSY_BIT = 15;
  localparam int          ACT_ID_LSB   = 8;
  localparam int          CTRL_EN_BIT  = 1;
  localparam int          CTRL_RST_BIT = 0;
  // Trigger action codes
  localparam logic [1:0]  TRIG_BLOCK   = 2'h0;
  localparam logic [1:0]  TRIG_RSVD    = 2'h1;
  localparam logic [1:0]  TRIG_BEAT    = 2'h2;
  localparam logic [1:0]  TRIG_TRANS   = 2'h3;
  // Interrupt event bits
  localparam int          EV_BUS_ERR   = 0;
  localparam int          EV_ABORTED   = 1;
  localparam int          EV_WRITEBACK = 2;
  localparam int          NUM_EV       = 3;
  // Write-back layout: descriptor stride and count offset in bytes
  localparam logic [31:0] DESC_BYTES   = 32'h0000_0010;
  localparam logic [31:0] CNT_OFS      = 32'h0000_0002;
endpackage

// file: dv/wb_memory_model.sv
// Write-back memory model answering count fetches and storing write-backs
`timescale 1ns/1ps
module wb_memory_model #(
  parameter logic [15:0] EMPTY_WORD = 16'h5a5a
) (
  // Clock
  input  wire logic        i_clk,
  // Write-back from the block
  input  wire logic        i_wb_valid,
  input  wire logic [31:0] i_wb_addr,
  input  wire logic [15:0] i_wb_count,
  // Fetch request from the bench
  input  wire logic        i_fetch,
  input  wire logic [31:0] i_fetch_addr,
  // Count load into the block
  output logic             o_cnt_load,
  output logic [15:0]      o_cnt_value
);
  logic [15:0] mem [logic [31:0]];
  initial begin
    o_cnt_load = 1'b0;
    o_cnt_value = 16'h0;
  end
  always @(posedge i_clk) begin
    if (i_wb_valid) begin
      mem[i_wb_addr] = i_wb_count;
    end
    o_cnt_load <= i_fetch;
    if (i_fetch) begin
      o_cnt_value <= mem.exists(i_fetch_addr) ? mem[i_fetch_addr] : EMPTY_WORD;
    end else begin
      // Stale outside a load, so a late sample cannot pass
      o_cnt_value <= ~o_cnt_value;
    end
  end
endmodule

// file: dv/tb_dma_channel_status_select.sv
// Self-checking bench for the channel status and selection block
`timescale 1ns/1ps
module tb_dma_channel_status_select;
  localparam int NCH = dma_status_pkg::NUM_CH;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, desc_base, wb_addr, fetch_addr;
  logic              wr_prot, dmac_en, grant, cnt_load, beat_done;
  logic              wb_valid, irq, fetch;
  logic [NCH-1:0]    pend_set, trig_start, bus_err, ch_active, abort_done;
  logic [NCH-1:0]    ch_enable, abort_req;
  logic [3:0]        lvl_req, grant_ch, lvl;
  logic [15:0]       cnt_value, wb_count;
  logic [2*NCH-1:0]  trig_act;
  logic [31:0]       dbase, wbase;
  logic [1:0]        code_exp;
  logic [64:0]       exp_rd [$];
  logic [47:0]       exp_wb [$];
  logic [64:0]       e;
  int                fails, compares;
  int                chs [3] = '{0, 5, 11};

  dma_channel_status_select #(.NCH(NCH)) dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_WR_PROTECT(wr_prot), .I_DMAC_EN(dmac_en), .I_PEND_SET(pend_set),
    .I_TRIG_START(trig_start), .I_BUS_ERR(bus_err),
    .I_CH_ACTIVE(ch_active), .I_ABORT_DONE(abort_done),
    .I_LVL_REQ(lvl_req), .I_GRANT(grant), .I_GRANT_CH(grant_ch),
    .I_CNT_LOAD(cnt_load), .I_CNT_VALUE(cnt_value),
    .I_BEAT_DONE(beat_done), .O_CH_ENABLE(ch_enable),
    .O_ABORT_REQ(abort_req), .O_TRIG_ACT(trig_act),
    .O_DESC_BASE(desc_base), .O_WB_VALID(wb_valid), .O_WB_ADDR(wb_addr),
    .O_WB_COUNT(wb_count), .O_IRQ(irq));

  wb_memory_model mem (
    .i_clk(clk), .i_wb_valid(wb_valid), .i_wb_addr(wb_addr),
    .i_wb_count(wb_count), .i_fetch(fetch), .i_fetch_addr(fetch_addr),
    .o_cnt_load(cnt_load), .o_cnt_value(cnt_value));

  always #25 clk = ~clk;

  task automatic chk(input string name, input logic [47:0] seen,
                     input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One idle edge first, so release and next setup never share a step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
                     input logic [32:0] x);
    exp_rd.push_back({x[32], m, x[31:0]});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    rdm(a, 32'hffff_ffff, x);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Results are judged here as they appear at the ports
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = (exp_rd.size() > 0) ? exp_rd.pop_front() : {1'b1, {64{1'b0}}};
      chk("rdata", {pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
    end
    if (wb_valid === 1'b1) begin
      if (exp_wb.size() > 0)
        chk("writeback", {wb_addr, wb_count}, exp_wb.pop_front());
      else
        chk("writeback", 48'h1, 48'h0);
    end
  end

  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata, wr_prot, dmac_en} = '0;
    {pend_set, trig_start, bus_err, ch_active, abort_done} = '0;
    {lvl_req, grant, grant_ch, beat_done, fetch, fetch_addr} = '0;
    rst = 1'b1;
    fails = 0;
    compares = 0;
    void'($urandom(56));
    idle(20);
    rst <= 1'b0;
    rd(dma_status_pkg::ADDR_PEND, 33'h0);
    rd(dma_status_pkg::ADDR_ACTIVE, 33'h0);
    rd(dma_status_pkg::ADDR_DESC, 33'h0);
    rd(dma_status_pkg::ADDR_WRB, 33'h0);
    rd(dma_status_pkg::ADDR_CHSEL, 33'h0);
    rd(dma_status_pkg::ADDR_CTRL, 33'h0);
    rd(12'h004, {1'b1, 32'h0});
    dbase = $urandom;
    wbase = $urandom;
    wr(dma_status_pkg::ADDR_DESC, dbase);
    wr(dma_status_pkg::ADDR_WRB, wbase);
    wr_prot <= 1'b1;
    wr(dma_status_pkg::ADDR_DESC, ~dbase);
    wr_prot <= 1'b0;
    dmac_en <= 1'b1;
    wr(dma_status_pkg::ADDR_WRB, ~wbase);
    rd(dma_status_pkg::ADDR_DESC, {1'b0, dbase});
    rd(dma_status_pkg::ADDR_WRB, {1'b0, wbase});
    chk("desc_base", desc_base, dbase);
    foreach (chs[i]) begin
      wr(dma_status_pkg::ADDR_CHSEL, 32'(chs[i]));
      wr(dma_status_pkg::ADDR_CTRL, 32'h2);
      rd(dma_status_pkg::ADDR_CTRL, 33'h2);
    end
    dmac_en <= 1'b0;
    chk("enables", ch_enable, 12'h821);
    wr(dma_status_pkg::ADDR_CHSEL, 32'hc);
    rd(dma_status_pkg::ADDR_CTRL, 33'h0);
    pend_set <= 12'h823;
    idle(1);
    pend_set <= '0;
    rd(dma_status_pkg::ADDR_PEND, 33'h821);
    trig_start <= 12'h001;
    bus_err <= 12'h020;
    idle(1);
    {trig_start, bus_err} <= '0;
    rd(dma_status_pkg::ADDR_PEND, 33'h800);
    wr(dma_status_pkg::ADDR_CHSEL, 32'hb);
    wr(dma_status_pkg::ADDR_CTRL, 32'h0);
    rd(dma_status_pkg::ADDR_PEND, 33'h0);
    chk("enables", ch_enable, 12'h021);
    wr(dma_status_pkg::ADDR_CHSEL, 32'h5);
    wr(dma_status_pkg::ADDR_TRIG, 32'h2);
    wr(dma_status_pkg::ADDR_CHSEL, 32'h0);
    code_exp = 2'h0;
    for (int c = 0; c < 4; c++) begin
      wr(dma_status_pkg::ADDR_TRIG, 32'(c));
      if (c != 1)
        code_exp = 2'(c);
      idle(1);
      chk("trig_act", trig_act[1:0], code_exp);
    end
    chk("trig_all", trig_act, 24'h000803);
    // Soft reset with enable kept at one must be ignored
    wr(dma_status_pkg::ADDR_CTRL, 32'h3);
    rd(dma_status_pkg::ADDR_CTRL, 33'h2);
    wr(dma_status_pkg::ADDR_CTRL, 32'h0);
    wr(dma_status_pkg::ADDR_CTRL, 32'h1);
    idle(3);
    rd(dma_status_pkg::ADDR_CTRL, 33'h0);
    chk("trig_all", trig_act, 24'h000800);
    wr(dma_status_pkg::ADDR_CHSEL, 32'h5);
    ch_active <= 12'h020;
    wr(dma_status_pkg::ADDR_CTRL, 32'h0);
    rd(dma_status_pkg::ADDR_CTRL, 33'h2);
    chk("abort_req", abort_req, 12'h020);
    abort_done <= 12'h020;
    idle(1);
    {abort_done, ch_active} <= '0;
    rd(dma_status_pkg::ADDR_CTRL, 33'h0);
    chk("enables", {abort_req, ch_enable}, 24'h0);
    lvl = 4'($urandom);
    lvl_req <= lvl;
    // Count is read only while busy is expected high
    fetch <= 1'b1;
    fetch_addr <= wbase + 32'h2;
    idle(1);
    fetch <= 1'b0;
    rd(dma_status_pkg::ADDR_ACTIVE, {17'h0b4b5, 11'h0, lvl});
    beat_done <= 1'b1;
    idle(1);
    beat_done <= 1'b0;
    exp_wb.push_back({wbase + 32'h2, 16'h5a59});
    grant_ch <= 4'h7;
    grant <= 1'b1;
    idle(1);
    grant <= 1'b0;
    rdm(dma_status_pkg::ADDR_ACTIVE, 32'h0000_ffff,
        {25'h7, 4'h0, lvl});
    fetch <= 1'b1;
    idle(1);
    fetch <= 1'b0;
    rd(dma_status_pkg::ADDR_ACTIVE,
       {17'h0b4b3, 2'h0, 5'h7, 4'h0, lvl});
    exp_wb.push_back({wbase + 32'h72, 16'h5a59});
    grant_ch <= 4'h3;
    grant <= 1'b1;
    idle(1);
    grant <= 1'b0;
    rdm(dma_status_pkg::ADDR_ACTIVE, 32'h0000_ffff,
        {25'h3, 4'h0, lvl});
    rd(dma_status_pkg::ADDR_IRQ_STAT, 33'h7);
    wr(dma_status_pkg::ADDR_IRQ_MASK, 32'h1);
    idle(2);
    chk("irq", irq, 1'b1);
    wr(dma_status_pkg::ADDR_IRQ_MASK, 32'h0);
    idle(2);
    chk("irq", irq, 1'b0);
    wr(dma_status_pkg::ADDR_IRQ_MASK, 32'h4);
    wr(dma_status_pkg::ADDR_IRQ_STAT, 32'h7);
    idle(2);
    chk("irq", irq, 1'b0);
    rd(dma_status_pkg::ADDR_IRQ_STAT, 33'h0);
    idle(4);
    chk("pending_notes", exp_rd.size() + exp_wb.size(), 48'h0);
    print_verdict();
  end
endmodule
